// *** hicr_pkg.sv ***
// Package for the hub identity and first configuration byte registers.
// Assumes one clock, synchronous active-high reset, byte-wide register port.
package hicr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] hicr_ofs_vendor_low   = 8'h00;
  localparam logic [7:0] hicr_ofs_vendor_high  = 8'h01;
  localparam logic [7:0] hicr_ofs_product_low  = 8'h02;
  localparam logic [7:0] hicr_ofs_product_high = 8'h03;
  localparam logic [7:0] hicr_ofs_release_low  = 8'h04;
  localparam logic [7:0] hicr_ofs_release_high = 8'h05;
  localparam logic [7:0] hicr_ofs_config_first = 8'h06;
  localparam int         hicr_reg_count        = 7;

  // ----------------------------------------------------------------
  // Field positions and values after reset
  // ----------------------------------------------------------------
  localparam int         hicr_power_source_bit = 7;
  localparam logic [7:0] hicr_rst_vendor_low   = 8'h00;
  localparam logic [7:0] hicr_rst_vendor_high  = 8'h00;
  localparam logic [7:0] hicr_rst_product_low  = 8'h00;
  localparam logic [7:0] hicr_rst_product_high = 8'h00;
  localparam logic [7:0] hicr_rst_release_low  = 8'h00;
  localparam logic [7:0] hicr_rst_release_high = 8'h00;
  localparam logic [7:0] hicr_rst_config_first = 8'h00;
  localparam logic [7:0] hicr_rd_unmapped      = 8'h00;
  localparam logic [hicr_reg_count*8-1:0] hicr_rst_image =
    {hicr_rst_config_first, hicr_rst_release_high, hicr_rst_release_low,
     hicr_rst_product_high, hicr_rst_product_low, hicr_rst_vendor_high,
     hicr_rst_vendor_low};

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } hicr_wr_type;

  typedef struct packed {
    logic [15:0] vendor_code;
    logic [15:0] product_code;
    logic [15:0] release_number;
    logic        self_powered;
  } hicr_desc_type;

  typedef enum logic [1:0] {
    hicr_src_none   = 2'b00,
    hicr_src_eeprom = 2'b01,
    hicr_src_smbus  = 2'b10
  } hicr_src_type;

endpackage

// *** hicr_byte_store.sv ***
// Byte store for the identity and configuration registers.
// Assumes the caller resolves write sources; one write per cycle.
`timescale 1ns/1ps
module hicr_byte_store
(
  input  wire logic                                   clock,
  input  wire logic                                   reset,
  input  wire logic                                   wr_en,
  input  wire logic [7:0]                             wr_addr,
  input  wire logic [7:0]                             wr_data,
  input  wire logic [7:0]                             rd_addr,
  output logic      [7:0]                             rd_data_ff,
  output logic      [hicr_pkg::hicr_reg_count*8-1:0]  image_ff
);

  // ----------------------------------------------------------------
  // Storage, one byte per entry
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < hicr_pkg::hicr_reg_count; gi++)
    begin : g_byte
      always_ff @(posedge clock)
      begin
        if (reset)
          image_ff[gi*8 +: 8] <= hicr_pkg::hicr_rst_image[gi*8 +: 8];
        else if (wr_en && (wr_addr == 8'(gi)))
          image_ff[gi*8 +: 8] <= wr_data;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered read port
  // ----------------------------------------------------------------
  logic [7:0] nxt_rd_data;

  always_comb
  begin
    nxt_rd_data = hicr_pkg::hicr_rd_unmapped;
    for (int i = 0; i < hicr_pkg::hicr_reg_count; i++)
    begin
      if (rd_addr == 8'(i))
        nxt_rd_data = image_ff[i*8 +: 8];
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      rd_data_ff <= hicr_pkg::hicr_rd_unmapped;
    else
      rd_data_ff <= nxt_rd_data;
  end

endmodule

// *** hicr_regs.sv ***
// Hub identity and first configuration byte register bank.
// Assumes byte writes from a configuration EEPROM loader and an SMBus slave,
// a plain SMBus read address, and an asynchronous local supply sense pin.
`timescale 1ns/1ps
module hicr_regs
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire hicr_pkg::hicr_wr_type eeprom_wr,
  input  wire hicr_pkg::hicr_wr_type smbus_wr,
  input  wire logic [7:0]            smbus_rd_addr,
  output logic [7:0]                 smbus_rd_data_ff,
  input  wire logic                  dyn_power_switch_en,
  input  wire logic                  local_supply_sense,
  output hicr_pkg::hicr_desc_type    desc_ff,
  output logic [7:0]                 config_first_ff,
  output logic [1:0]                 last_src_ff,
  output logic                       wr_ignored_ff
);

  // ----------------------------------------------------------------
  // Write source selection
  // ----------------------------------------------------------------
  // SMBus wins a same-cycle collision: the host is the later authority and
  // an EEPROM load normally finishes before the host is allowed in.
  logic                   sel_en;
  logic [7:0]             sel_addr;
  logic [7:0]             sel_data;
  hicr_pkg::hicr_src_type sel_src;
  logic                   sel_mapped;

  always_comb
  begin
    sel_en   = 1'b0;
    sel_addr = 8'h00;
    sel_data = 8'h00;
    sel_src  = hicr_pkg::hicr_src_none;
    if (smbus_wr.valid)
    begin
      sel_en   = 1'b1;
      sel_addr = smbus_wr.addr;
      sel_data = smbus_wr.data;
      sel_src  = hicr_pkg::hicr_src_smbus;
    end
    else if (eeprom_wr.valid)
    begin
      sel_en   = 1'b1;
      sel_addr = eeprom_wr.addr;
      sel_data = eeprom_wr.data;
      sel_src  = hicr_pkg::hicr_src_eeprom;
    end
  end

  assign sel_mapped = (sel_addr <= hicr_pkg::hicr_ofs_config_first);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [hicr_pkg::hicr_reg_count*8-1:0] image;

  hicr_byte_store u_store
  (
    .clock      (clock),
    .reset      (reset),
    .wr_en      (sel_en && sel_mapped),
    .wr_addr    (sel_addr),
    .wr_data    (sel_data),
    .rd_addr    (smbus_rd_addr),
    .rd_data_ff (smbus_rd_data_ff),
    .image_ff   (image)
  );

  // ----------------------------------------------------------------
  // Write bookkeeping
  // ----------------------------------------------------------------
  // Loser of a collision and unmapped writes are both flagged as ignored.
  // The dropped EEPROM byte is not retried: the loader must not overlap the host.
  logic collision;
  logic unmapped_wr;
  logic nxt_wr_ignored;

  assign collision   = smbus_wr.valid && eeprom_wr.valid;
  assign unmapped_wr = sel_en && !sel_mapped;

  always_comb
  begin
    nxt_wr_ignored = 1'b0;
    if (collision)
      nxt_wr_ignored = 1'b1;
    else if (unmapped_wr)
      nxt_wr_ignored = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      last_src_ff <= hicr_pkg::hicr_src_none;
    else if (sel_en && sel_mapped)
      last_src_ff <= sel_src;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      wr_ignored_ff <= 1'b0;
    else
      wr_ignored_ff <= nxt_wr_ignored;
  end

  // ----------------------------------------------------------------
  // Local supply sense synchroniser
  // ----------------------------------------------------------------
  // Pin is asynchronous; accepted only when stages two and three agree.
  logic sense_s1_ff;
  logic sense_s2_ff;
  logic sense_s3_ff;
  logic sense_level_ff;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sense_s1_ff <= 1'b0;
      sense_s2_ff <= 1'b0;
      sense_s3_ff <= 1'b0;
    end
    else
    begin
      sense_s1_ff <= local_supply_sense;
      sense_s2_ff <= sense_s1_ff;
      sense_s3_ff <= sense_s2_ff;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      sense_level_ff <= 1'b0;
    else if (sense_s2_ff == sense_s3_ff)
      sense_level_ff <= sense_s3_ff;
  end

  // ----------------------------------------------------------------
  // Effective power source
  // ----------------------------------------------------------------
  logic [7:0] cfg_first;
  logic       cfg_self_powered;
  logic       nxt_self_powered;

  assign cfg_first        = image[hicr_pkg::hicr_ofs_config_first*8 +: 8];
  assign cfg_self_powered = cfg_first[hicr_pkg::hicr_power_source_bit];

  // Enable is a same-domain level, not synchronised here
  always_comb
  begin
    nxt_self_powered = cfg_self_powered;
    if (dyn_power_switch_en)
      nxt_self_powered = sense_level_ff;
  end

  // ----------------------------------------------------------------
  // Descriptor view for enumeration
  // ----------------------------------------------------------------
  // One cycle behind the store; enumeration reads far slower than this.
  // High byte at the odd offset; the two bytes are not updated atomically,
  // so a word read between its two writes may be mixed.
  logic [15:0]             vendor_code;
  logic [15:0]             product_code;
  logic [15:0]             release_number;
  hicr_pkg::hicr_desc_type nxt_desc;

  assign vendor_code    = {image[hicr_pkg::hicr_ofs_vendor_high*8 +: 8],
                           image[hicr_pkg::hicr_ofs_vendor_low*8 +: 8]};
  assign product_code   = {image[hicr_pkg::hicr_ofs_product_high*8 +: 8],
                           image[hicr_pkg::hicr_ofs_product_low*8 +: 8]};
  assign release_number = {image[hicr_pkg::hicr_ofs_release_high*8 +: 8],
                           image[hicr_pkg::hicr_ofs_release_low*8 +: 8]};

  always_comb
  begin
    nxt_desc.vendor_code    = vendor_code;
    nxt_desc.product_code   = product_code;
    nxt_desc.release_number = release_number;
    nxt_desc.self_powered   = nxt_self_powered;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      desc_ff <= '0;
    else
      desc_ff <= nxt_desc;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      config_first_ff <= hicr_pkg::hicr_rst_config_first;
    else
      config_first_ff <= cfg_first;
  end

endmodule

// *** hicr_checker.sv ***
// Port checker for hicr_regs, bound at the foot.
// Assumes one clock, sync active-high reset.
`timescale 1ns/1ps
module hicr_checker
(
  input wire logic                    clock,
  input wire logic                    reset,
  input wire hicr_pkg::hicr_wr_type   eeprom_wr,
  input wire hicr_pkg::hicr_wr_type   smbus_wr,
  input wire logic                    dyn_power_switch_en,
  input wire logic                    local_supply_sense,
  input wire hicr_pkg::hicr_desc_type desc_ff,
  input wire logic [7:0]              config_first_ff,
  input wire logic [1:0]              last_src_ff,
  input wire logic                    wr_ignored_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_byte(a, f);
    smbus_wr.valid && smbus_wr.addr == a |-> ##2 f == $past(smbus_wr.data, 2);
  endproperty
  a_vendor_low: assert property (p_byte(8'h00, desc_ff.vendor_code[7:0])) else $error("vendor low");
  a_vendor_high: assert property (p_byte(8'h01, desc_ff.vendor_code[15:8])) else $error("vendor high");
  a_release_low: assert property (p_byte(8'h04, desc_ff.release_number[7:0])) else $error("release low");
  a_product_low: assert property (p_byte(8'h02, desc_ff.product_code[7:0])) else $error("product low");
  a_product_high: assert property (p_byte(8'h03, desc_ff.product_code[15:8])) else $error("product high");
  a_release_high: assert property (p_byte(8'h05, desc_ff.release_number[15:8])) else $error("release");
  a_eeprom_path: assert property (eeprom_wr.valid && !smbus_wr.valid && eeprom_wr.addr <= 8'h06
    |=> last_src_ff == 2'b01) else $error("eeprom write lost");
  a_smbus_wins: assert property (eeprom_wr.valid && smbus_wr.valid && smbus_wr.addr <= 8'h06
    |=> last_src_ff == 2'b10 && wr_ignored_ff) else $error("collision");
  a_unmapped_write: assert property (smbus_wr.valid && smbus_wr.addr > 8'h06
    |=> wr_ignored_ff) else $error("unmapped write not flagged");
  a_power_bit: assert property ((!dyn_power_switch_en)[*2]
    |-> desc_ff.self_powered == config_first_ff[7]) else $error("power bit");
  a_sense_used: assert property ((dyn_power_switch_en && $stable(local_supply_sense))[*7]
    |-> desc_ff.self_powered == local_supply_sense) else $error("sense ignored");
  c_collision: cover property (eeprom_wr.valid && smbus_wr.valid);
  c_sense_wins: cover property (dyn_power_switch_en && desc_ff.self_powered && !config_first_ff[7]);
  c_eeprom_load: cover property (last_src_ff == 2'b01);
endmodule

bind hicr_regs hicr_checker u_chk (.clock, .reset, .eeprom_wr, .smbus_wr, .dyn_power_switch_en,
  .local_supply_sense, .desc_ff, .config_first_ff, .last_src_ff, .wr_ignored_ff);

// *** hicr_eeprom_model.sv ***
// EEPROM loader model: after go, byte {4'hA, i} to offset i, i = 0..6.
// Assumes go pulses for one cycle.
`timescale 1ns/1ps
module hicr_eeprom_model
(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             go,
  output hicr_pkg::hicr_wr_type eeprom_wr
);
  logic [3:0] idx_ff;
  logic [3:0] cur;
  assign cur = go ? 4'h0 : idx_ff;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      idx_ff <= 4'h7;
      eeprom_wr <= '0;
    end
    else if (cur < 4'h7)
    begin
      idx_ff <= cur + 4'h1;
      eeprom_wr <= {1'b1, 4'h0, cur, 4'hA, cur};
    end
    else
      eeprom_wr <= {1'b0, ~eeprom_wr.addr, ~eeprom_wr.data}; // Idle lines toggle, never hold old byte
  end
endmodule

// *** testbench.sv ***
// Bench for hicr_regs with the EEPROM model.
// Assumes the checker is bound in.
`timescale 1ns/1ps
module testbench;
  logic                    clock, go = 0, dyn_power_switch_en = 0, local_supply_sense = 0, wr_ignored_ff;
  logic                    reset = 1;
  logic [7:0]              smbus_rd_addr = 8'h00, smbus_rd_data_ff, config_first_ff;
  logic [1:0]              last_src_ff;
  hicr_pkg::hicr_wr_type   eeprom_wr, smbus_wr = '0;
  hicr_pkg::hicr_desc_type desc_ff;
  int                      num_errors = 0, n_checks = 0, cycles = 0;
  // Offset, write data, read data
  logic [23:0]             rows [8] = '{24'h00_3434, 24'h01_1212, 24'h02_7878, 24'h03_5656,
                                        24'h04_0101, 24'h05_0202, 24'h06_8080, 24'h07_5500};
  hicr_regs dut (.clock, .reset, .eeprom_wr, .smbus_wr, .smbus_rd_addr, .smbus_rd_data_ff, .dyn_power_switch_en,
                 .local_supply_sense, .desc_ff, .config_first_ff, .last_src_ff, .wr_ignored_ff);
  hicr_eeprom_model model (.clock, .reset, .go, .eeprom_wr);
  task automatic print_verdict;
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Idle cycle after each write keeps strobes from re-rising in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    smbus_wr = {1'b1, a, d};
    step(1);
    smbus_wr.valid = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    smbus_rd_addr = a;
    step(1);
    chk(smbus_rd_data_ff, exp);
  endtask
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 1000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    step(4);
    reset = 1'b0;
    chk(desc_ff.vendor_code, 16'h0000);
    chk({last_src_ff, wr_ignored_ff, config_first_ff}, 16'h0000);
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    smbus_wr = {1'b1, 8'h07, 8'h55};
    step(1);
    smbus_wr.valid = 1'b0;
    chk({last_src_ff, wr_ignored_ff}, 3'b101);
    chk(config_first_ff, 8'h80);
    step(1);
    chk(desc_ff.vendor_code, 16'h1234);
    chk(desc_ff.product_code, 16'h5678);
    chk(desc_ff.release_number, 16'h0201);
    chk(desc_ff.self_powered, 1'b1);
    wr(8'h06, 8'h7F);
    chk(desc_ff.self_powered, 1'b0);
    chk(config_first_ff, 8'h7F);
    {dyn_power_switch_en, local_supply_sense} = 2'b11;
    step(8);
    chk(desc_ff.self_powered, 1'b1);
    wr(8'h06, 8'h80);
    local_supply_sense = 1'b0;
    step(8);
    chk(desc_ff.self_powered, 1'b0);
    dyn_power_switch_en = 1'b0;
    go = 1'b1;
    step(1);
    go = 1'b0;
    smbus_wr = {1'b1, 8'h00, 8'hEE};
    step(1);
    smbus_wr.valid = 1'b0;
    chk({last_src_ff, wr_ignored_ff, desc_ff.self_powered}, 4'b1011);
    step(8);
    chk(desc_ff.vendor_code, 16'hA1EE);
    chk(last_src_ff, 2'b01);
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    chk(desc_ff.vendor_code, 16'h0000);
    chk({last_src_ff, wr_ignored_ff, config_first_ff}, 16'h0000);
    rd(8'h01, 8'h00);
    print_verdict();
  end
endmodule
